// *** verilog/ast_pkg.sv ***
// Constants, register map and carrier types for the async serial transceiver.
// Assumes a 100 MHz clock and a 32-bit APB master on the register side.
package ast_pkg;
  // Register byte offsets
  localparam logic [7:0] AST_OFS_CTRL1 = 8'h00;
  localparam logic [7:0] AST_OFS_CTRL2 = 8'h04;
  localparam logic [7:0] AST_OFS_CTRL3 = 8'h08;
  localparam logic [7:0] AST_OFS_STAT1 = 8'h0C;
  localparam logic [7:0] AST_OFS_STAT2 = 8'h10;
  localparam logic [7:0] AST_OFS_DATA = 8'h14;
  localparam logic [7:0] AST_OFS_BAUD = 8'h18;
  // control_reg_one fields
  localparam int AST_C1_ENABLE = 0;
  localparam int AST_C1_CHAR9 = 1;
  localparam int AST_C1_INVERT = 2;
  // control_reg_two fields
  localparam int AST_C2_TXEN = 0;
  localparam int AST_C2_RXEN = 1;
  localparam int AST_C2_BREAK = 2;
  localparam int AST_C2_TEIE = 3;
  localparam int AST_C2_TX_COMPLETE_IRQ_EN = 4;
  localparam int AST_C2_RFIE = 5;
  // control_reg_three fields
  localparam int AST_C3_T8 = 0;
  localparam int AST_C3_R8 = 1;
  // status_reg_one fields
  localparam int AST_S1_TXE = 0;
  localparam int AST_S1_TC = 1;
  localparam int AST_S1_RXF = 2;
  localparam int AST_S1_NF = 3;
  localparam int AST_S1_FE = 4;
  // status_reg_two fields
  localparam int AST_S2_BKF = 0;
  localparam int AST_S2_RPF = 1;
  // Reset values
  localparam logic [7:0] AST_BAUD_RST = 8'h00;
  // Sample tick timing and frame bit counts
  localparam logic [3:0] AST_TICKS_LAST = 4'hF;
  localparam logic [3:0] AST_RT_VER = 4'h7;
  localparam logic [3:0] AST_RT_DEC = 4'hA;
  localparam logic [3:0] AST_BITS8 = 4'hA;
  localparam logic [3:0] AST_BITS9 = 4'hB;

  typedef struct packed {
    logic module_enable;
    logic char9;
    logic tx_invert;
    logic tx_enable;
    logic rx_enable;
    logic send_break;
    logic tx_empty_irq_en;
    logic tx_complete_irq_en;
    logic rx_full_irq_en;
    logic tx_ninth_bit;
  } ast_ctrl_t;

  localparam ast_ctrl_t AST_CTRL_RST = '0;
endpackage

// *** verilog/ast_top.sv ***
// Async serial transceiver: APB register slave, shared baud generator,
// transmitter and 16x oversampling receiver in one module.
// Assumes one 100 MHz clock; serial_in_pin is asynchronous to it.
//
// Chosen here: the placing of the registers and register access over APB.
`timescale 1ns/100ps
module ast_top
  import ast_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  output logic serial_out_pin_oe,
  output logic tx_irq,
  output logic rx_irq
);

  function automatic logic maj3(input logic [2:0] s);
    maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

  function automatic logic hit(input logic [31:0] a, input logic [7:0] ofs);
    hit = (a[31:8] == 24'h00_0000) && (a[7:0] == ofs);
  endfunction

  // Registers
  ast_ctrl_t ctrl_reg;
  logic [7:0] baud_reg;
  logic [7:0] bdiv_reg;
  logic tick_reg;
  logic [8:0] txbuf_reg;
  logic txbuf_full_reg;
  logic txe_reg;
  logic tc_reg;
  logic [10:0] tsh_reg;
  logic [3:0] tbits_reg;
  logic [3:0] tsub_reg;
  logic preamble_reg;
  logic brk_tail_reg;
  logic gen_reg;
  logic te_prev_reg;
  logic [8:0] rbuf_reg;
  logic r8_reg;
  logic rxf_reg;
  logic nf_reg;
  logic fe_reg;
  logic bkf_reg;
  logic s1_armed_reg;
  logic s2_armed_reg;
  logic rs1_reg;
  logic rs2_reg;
  logic [2:0] rhist_reg;
  logic rbusy_reg;
  logic [3:0] rrt_reg;
  logic [3:0] ridx_reg;
  logic [2:0] rsamp_reg;
  logic [8:0] rsh_reg;
  logic rnoise_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic txd_reg;
  logic txoe_reg;
  logic tx_irq_reg;
  logic rx_irq_reg;

  // Bus decode
  wire logic setup = psel & ~penable;
  wire logic acc = psel & penable & pready_reg;
  wire logic wr = acc & pwrite;
  wire logic rd = acc & ~pwrite;
  wire logic h_c1 = hit(paddr, AST_OFS_CTRL1);
  wire logic h_c2 = hit(paddr, AST_OFS_CTRL2);
  wire logic h_c3 = hit(paddr, AST_OFS_CTRL3);
  wire logic h_s1 = hit(paddr, AST_OFS_STAT1);
  wire logic h_s2 = hit(paddr, AST_OFS_STAT2);
  wire logic h_dt = hit(paddr, AST_OFS_DATA);
  wire logic h_bd = hit(paddr, AST_OFS_BAUD);
  wire logic mapped = h_c1 | h_c2 | h_c3 | h_s1 | h_s2 | h_dt | h_bd;
  wire logic en = ctrl_reg.module_enable;
  wire logic wr_data = wr & h_dt;
  wire logic rd_data = rd & h_dt;

  wire logic [31:0] rd_mux =
    h_c1 ? {29'h0, ctrl_reg.tx_invert, ctrl_reg.char9, ctrl_reg.module_enable} :
    h_c2 ? {26'h0, ctrl_reg.rx_full_irq_en, ctrl_reg.tx_complete_irq_en,
            ctrl_reg.tx_empty_irq_en, ctrl_reg.send_break, ctrl_reg.rx_enable,
            ctrl_reg.tx_enable} :
    h_c3 ? {30'h0, r8_reg, ctrl_reg.tx_ninth_bit} :
    h_s1 ? {27'h0, fe_reg, nf_reg, rxf_reg, tc_reg, txe_reg} :
    h_s2 ? {30'h0, rbusy_reg, bkf_reg} :
    h_dt ? {24'h0, rbuf_reg[7:0]} :
    h_bd ? {24'h0, baud_reg} : 32'h0000_0000;

  always_ff @(posedge clk) begin
    if (rst) begin
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      prdata_reg <= setup ? rd_mux : 32'h0000_0000;
      pready_reg <= setup;
      pslverr_reg <= setup & ~mapped;
    end
  end

  // Control registers
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_reg <= AST_CTRL_RST;
      baud_reg <= AST_BAUD_RST;
    end else if (wr) begin
      if (h_c1) begin
        ctrl_reg.module_enable <= pwdata[AST_C1_ENABLE];
        ctrl_reg.char9 <= pwdata[AST_C1_CHAR9];
        ctrl_reg.tx_invert <= pwdata[AST_C1_INVERT];
      end
      if (h_c2) begin
        ctrl_reg.tx_enable <= pwdata[AST_C2_TXEN];
        ctrl_reg.rx_enable <= pwdata[AST_C2_RXEN];
        ctrl_reg.send_break <= pwdata[AST_C2_BREAK];
        ctrl_reg.tx_empty_irq_en <= pwdata[AST_C2_TEIE];
        ctrl_reg.tx_complete_irq_en <= pwdata[AST_C2_TX_COMPLETE_IRQ_EN];
        ctrl_reg.rx_full_irq_en <= pwdata[AST_C2_RFIE];
      end
      if (h_c3) begin
        ctrl_reg.tx_ninth_bit <= pwdata[AST_C3_T8];
      end
      if (h_bd) begin
        baud_reg <= pwdata[7:0];
      end
    end
  end

  // Baud tick: one pulse every baud_reg+1 clocks, shared by both directions
  always_ff @(posedge clk) begin
    if (rst || !en) begin
      bdiv_reg <= 8'h00;
      tick_reg <= 1'b0;
    end else begin
      bdiv_reg <= (bdiv_reg >= baud_reg) ? 8'h00 : bdiv_reg + 8'h01;
      tick_reg <= (bdiv_reg >= baud_reg);
    end
  end

  // Transmitter: decide what to load when the shifter runs dry
  wire logic tx_on = en & ctrl_reg.tx_enable;
  wire logic [3:0] nbits = ctrl_reg.char9 ? AST_BITS9 : AST_BITS8;
  wire logic bit_end = tick_reg & (tsub_reg == AST_TICKS_LAST);
  wire logic last_bit = bit_end & (tbits_reg == 4'h1);
  wire logic dry = (tbits_reg == 4'h0) | last_bit;
  wire logic te_rise = tx_on & ~te_prev_reg;
  wire logic ld_pre = dry & tx_on & (preamble_reg | te_rise);
  wire logic ld_brk = dry & tx_on & ~ld_pre & ctrl_reg.send_break;
  wire logic ld_one = dry & ~ld_pre & ~ld_brk & brk_tail_reg;
  wire logic ld_dat = dry & tx_on & ~ld_pre & ~ld_brk & ~ld_one & txbuf_full_reg;
  wire logic [10:0] frame = ctrl_reg.char9 ?
    {1'b1, ctrl_reg.tx_ninth_bit, txbuf_reg[7:0], 1'b0} :
    {2'b11, txbuf_reg[7:0], 1'b0};

  always_ff @(posedge clk) begin
    if (rst || !en) begin
      tsh_reg <= 11'h7FF;
      tbits_reg <= 4'h0;
      tsub_reg <= 4'h0;
      preamble_reg <= 1'b0;
      brk_tail_reg <= 1'b0;
      gen_reg <= 1'b0;
      te_prev_reg <= 1'b0;
    end else begin
      te_prev_reg <= tx_on;
      if (te_rise && !dry) begin
        preamble_reg <= 1'b1;
      end else if (ld_pre) begin
        preamble_reg <= 1'b0;
      end
      if (tick_reg) begin
        tsub_reg <= tsub_reg + 4'h1;
      end
      if (ld_pre) begin
        tsh_reg <= 11'h7FF;
        tbits_reg <= nbits;
        gen_reg <= 1'b1;
      end else if (ld_brk) begin
        tsh_reg <= 11'h000;
        tbits_reg <= nbits;
        brk_tail_reg <= 1'b1;
        gen_reg <= 1'b1;
      end else if (ld_one) begin
        tsh_reg <= 11'h7FF;
        tbits_reg <= 4'h1;
        brk_tail_reg <= 1'b0;
        gen_reg <= 1'b1;
      end else if (ld_dat) begin
        tsh_reg <= frame;
        tbits_reg <= nbits;
        gen_reg <= 1'b0;
      end else if (last_bit) begin
        tsh_reg <= 11'h7FF;
        tbits_reg <= 4'h0;
        gen_reg <= 1'b0;
      end else if (bit_end && tbits_reg != 4'h0) begin
        tsh_reg <= {1'b1, tsh_reg[10:1]};
        tbits_reg <= tbits_reg - 4'h1;
      end
      // Idle pins the bit timer at zero so a frame started from idle gets a full first bit
      if (tbits_reg == 4'h0) begin
        tsub_reg <= 4'h0;
      end
    end
  end

  // Transmit buffer; a write during handoff still lands, so nothing is dropped
  always_ff @(posedge clk) begin
    if (rst) begin
      txbuf_reg <= 9'h000;
      txbuf_full_reg <= 1'b0;
      txe_reg <= 1'b1;
      tc_reg <= 1'b1;
    end else begin
      if (wr_data) begin
        txbuf_reg <= {1'b0, pwdata[7:0]};
        txbuf_full_reg <= 1'b1;
        txe_reg <= ld_dat | ~s1_armed_reg; // Handoff set wins over the clearing write
      end else if (ld_dat) begin
        txbuf_full_reg <= 1'b0;
        txe_reg <= 1'b1;
      end
      tc_reg <= ~txbuf_full_reg & (tbits_reg == 4'h0) & ~gen_reg
                & ~preamble_reg & ~brk_tail_reg;
    end
  end

  // Pin drive and transmit request, all registered
  always_ff @(posedge clk) begin
    if (rst) begin
      txd_reg <= 1'b1;
      txoe_reg <= 1'b0;
      tx_irq_reg <= 1'b0;
    end else begin
      txd_reg <= tsh_reg[0] ^ ctrl_reg.tx_invert;
      txoe_reg <= en;
      tx_irq_reg <= (txe_reg & ctrl_reg.tx_empty_irq_en)
                    | (tc_reg & ctrl_reg.tx_complete_irq_en);
    end
  end

  // Receiver input synchroniser; only rs2_reg feeds logic
  always_ff @(posedge clk) begin
    if (rst) begin
      rs1_reg <= 1'b1;
      rs2_reg <= 1'b1;
    end else begin
      rs1_reg <= serial_in_pin;
      rs2_reg <= rs1_reg;
    end
  end

  // Receiver: rrt_reg counts sample ticks 1..16 inside each bit
  wire logic rx_on = en & ctrl_reg.rx_enable;
  wire logic [3:0] stop_idx = ctrl_reg.char9 ? 4'hA : 4'h9;
  wire logic [2:0] samp3 = {rsamp_reg[1:0], rs2_reg};
  wire logic dec = tick_reg & rbusy_reg & (rrt_reg == AST_RT_DEC);
  wire logic vbit = maj3(samp3);
  wire logic vnoise = (samp3 != 3'b000) & (samp3 != 3'b111);
  wire logic start_seen = tick_reg & ~rbusy_reg & (rhist_reg == 3'b111) & ~rs2_reg;
  wire logic ver_fail = tick_reg & rbusy_reg & (ridx_reg == 4'h0)
                        & (rrt_reg == AST_RT_VER) & maj3(samp3);
  wire logic done = dec & (ridx_reg == stop_idx);
  wire logic is_brk = done & ~vbit & (rsh_reg == 9'h000);
  wire logic sampling = (rrt_reg == 4'h3) | (rrt_reg == 4'h5) | (rrt_reg >= AST_RT_VER);

  always_ff @(posedge clk) begin
    if (rst || !rx_on) begin
      rhist_reg <= 3'b000;
      rbusy_reg <= 1'b0;
      rrt_reg <= 4'h0;
      ridx_reg <= 4'h0;
      rsamp_reg <= 3'b000;
      rsh_reg <= 9'h000;
      rnoise_reg <= 1'b0;
    end else if (tick_reg) begin
      rhist_reg <= {rhist_reg[1:0], rs2_reg};
      if (start_seen) begin
        rbusy_reg <= 1'b1;
        rrt_reg <= 4'h2;
        ridx_reg <= 4'h0;
        rsh_reg <= 9'h000;
        rnoise_reg <= 1'b0;
      end else if (rbusy_reg) begin
        rrt_reg <= rrt_reg + 4'h1;
        if (sampling) begin
          rsamp_reg <= samp3;
        end
        if (ver_fail || done) begin
          rbusy_reg <= 1'b0;
          rhist_reg <= 3'b000;
        end
        if (rrt_reg == AST_RT_VER && ridx_reg == 4'h0 && vnoise) begin
          rnoise_reg <= 1'b1;
        end
        if (dec) begin
          if (vnoise) begin
            rnoise_reg <= 1'b1;
          end
          if (ridx_reg != 4'h0 && ridx_reg != stop_idx) begin
            rsh_reg[ridx_reg - 4'h1] <= vbit;
          end
          ridx_reg <= ridx_reg + 4'h1;
        end
      end
    end
  end

  // Receive buffer and flags; a new set beats a clear in the same cycle
  wire logic rclr = rd_data & s1_armed_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      rbuf_reg <= 9'h000;
      r8_reg <= 1'b0;
      rxf_reg <= 1'b0;
      nf_reg <= 1'b0;
      fe_reg <= 1'b0;
      bkf_reg <= 1'b0;
      s1_armed_reg <= 1'b0;
      s2_armed_reg <= 1'b0;
    end else begin
      if (rd && h_s1) begin
        s1_armed_reg <= 1'b1;
      end else if (acc && (h_dt || h_s1)) begin
        s1_armed_reg <= 1'b0;
      end
      if (rd && h_s2) begin
        s2_armed_reg <= 1'b1;
      end else if (acc && (h_dt || h_s2)) begin
        s2_armed_reg <= 1'b0;
      end
      if (done) begin
        rbuf_reg <= is_brk ? 9'h000 : rsh_reg;
        r8_reg <= is_brk ? 1'b0 : (ctrl_reg.char9 ? rsh_reg[8] : rsh_reg[7]);
        rxf_reg <= 1'b1;
        fe_reg <= ~vbit;
        nf_reg <= rnoise_reg | vnoise;
      end else if (rclr) begin
        rxf_reg <= 1'b0;
        fe_reg <= 1'b0;
        nf_reg <= 1'b0;
      end
      if (is_brk) begin
        bkf_reg <= 1'b1;
      end else if (rd_data && s2_armed_reg) begin
        bkf_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rx_irq_reg <= 1'b0;
    end else begin
      rx_irq_reg <= rxf_reg & ctrl_reg.rx_full_irq_en;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign serial_out_pin = txd_reg;
  assign serial_out_pin_oe = txoe_reg;
  assign tx_irq = tx_irq_reg;
  assign rx_irq = rx_irq_reg;

endmodule // ast_top

// *** tb/ast_assertions.sv ***
// Port-level checker for ast_top, attached by bind.
// Assumes one clock, synchronous active-high reset, bit time of at least 16 clocks.
`timescale 1ns/100ps
module ast_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic serial_out_pin,
  input wire logic serial_out_pin_oe,
  input wire logic tx_irq,
  input wire logic rx_irq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Length of the current high run on the line, saturating
  logic [4:0] hi_cnt;
  always_ff @(posedge clk) begin
    if (rst || !serial_out_pin)
      hi_cnt <= 5'h00;
    else if (hi_cnt != 5'h1F)
      hi_cnt <= hi_cnt + 5'h01;
  end

  chk_ready_next: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  chk_ready_cause: assert property (pready |-> psel && penable && $past(psel && !penable))
    else $error("ready without setup");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  chk_err_zero: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
    else $error("error reply not clean");
  // A whole bit lasts 16 sample ticks, so any level change holds 16 clocks
  chk_bit_width: assert property (serial_out_pin_oe && $past(serial_out_pin_oe)
    && $changed(serial_out_pin) |=> ($stable(serial_out_pin) || !serial_out_pin_oe)[*8]
    ##1 ($stable(serial_out_pin) || !serial_out_pin_oe)[*7])
    else $error("bit shorter than 16 clocks");
  chk_high_before: assert property ($fell(serial_out_pin) && serial_out_pin_oe
    |-> hi_cnt >= 5'h10)
    else $error("fall without a full high bit");
  chk_reset_out: assert property ($fell(rst) |-> !serial_out_pin_oe && serial_out_pin
    && !tx_irq && !rx_irq && !pready)
    else $error("outputs wrong after reset");
  chk_quiet_off: assert property (!serial_out_pin_oe && $past(!serial_out_pin_oe)
    |-> $stable(serial_out_pin))
    else $error("line moves while released");

  cov_err: cover property (pslverr);
  cov_start: cover property ($fell(serial_out_pin) && serial_out_pin_oe);
  cov_rx_irq: cover property ($rose(rx_irq));
  cov_tx_irq: cover property ($rose(tx_irq));
endmodule // ast_checker

bind ast_top ast_checker u_chk (
  .clk(clk),
  .rst(rst),
  .psel(psel),
  .penable(penable),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .serial_out_pin(serial_out_pin),
  .serial_out_pin_oe(serial_out_pin_oe),
  .tx_irq(tx_irq),
  .rx_irq(rx_irq)
);

// *** tb/ast_remote.sv ***
// Remote serial device: sends frames LSB first and captures what it hears.
// Assumes a bit time of 16 clocks (baud divisor 0) and an idle-high line.
`timescale 1ns/100ps
module ast_remote (
  input wire logic clk,
  input wire logic line_in,
  output logic line_out
);
  logic [10:0] frame;
  int nfr = 0;
  initial line_out = 1'b1;

  task automatic send(input logic [10:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      line_out <= bits[i];
      repeat (15) @(posedge clk);
    end
    @(posedge clk);
    line_out <= 1'b1;
    repeat (31) @(posedge clk);
  endtask

  // Samples mid-bit; 11 samples cover a 9-bit frame, trailing idle otherwise
  always begin
    @(negedge line_in);
    repeat (8) @(posedge clk);
    for (int i = 0; i < 11; i++) begin
      frame[i] = line_in;
      repeat (16) @(posedge clk);
    end
    nfr++;
  end
endmodule // ast_remote

// *** tb/test_async_serial_transceiver.sv ***
// Self-checking bench for ast_top over APB with a remote serial device.
// Assumes baud divisor 0, so one bit is 16 clocks, except in one divisor check.
`timescale 1ns/100ps
module test_async_serial_transceiver;
  import ast_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0000_0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, q;
  logic pready, pslverr, err_q, sin, sout, soe, tx_irq, rx_irq;
  int err_total = 0;
  int n_tests = 0;
  int c, k;

  always #5 clk = ~clk;

  ast_top dut_u (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_in_pin(sin), .serial_out_pin(sout), .serial_out_pin_oe(soe),
    .tx_irq(tx_irq), .rx_irq(rx_irq));
  // Released line is pulled up
  ast_remote rem (.clk(clk), .line_in(soe ? sout : 1'b1), .line_out(sin));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {24'h00_0000, a};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(a, 1'b0, 32'h0000_0000);
    chk(q & m, e);
  endtask

  task automatic wait_out(input logic v);
    c = 0;
    while (sout !== v && c < 1000) begin
      @(posedge clk);
      c++;
    end
  endtask

  task automatic wait_frame;
    k = rem.nfr;
    while (rem.nfr == k) @(posedge clk);
  endtask

  task automatic t_reset;
    chk(32'({soe, sout}), 32'h0000_0001);
    rc(AST_OFS_STAT1, 32'h0000_0003, 32'h0000_0003);
    rc(8'h1C, 32'hFFFF_FFFF, 32'h0000_0000);
    chk(32'(err_q), 32'h0000_0001);
    $display("t_reset done");
  endtask

  task automatic t_tx;
    wr(AST_OFS_CTRL1, 32'h0000_0001);
    repeat (2) @(posedge clk);
    chk(32'(soe), 32'h0000_0001);
    wr(AST_OFS_CTRL2, 32'h0000_0001);
    rc(AST_OFS_STAT1, 32'h0000_0001, 32'h0000_0001);
    wr(AST_OFS_DATA, 32'h0000_00A5);
    rc(AST_OFS_STAT1, 32'h0000_0003, 32'h0000_0000);
    wait_out(1'b0);
    chk(32'(c >= 130 && c <= 180), 32'h0000_0001);
    wait_frame();
    chk(32'(rem.frame[9:0]), 32'h0000_034A);
    rc(AST_OFS_STAT1, 32'h0000_0003, 32'h0000_0003);
    wr(AST_OFS_CTRL1, 32'h0000_0003);
    wr(AST_OFS_CTRL3, 32'h0000_0001);
    rc(AST_OFS_STAT1, 32'h0000_0001, 32'h0000_0001);
    wr(AST_OFS_DATA, 32'h0000_003C);
    wait_frame();
    chk(32'(rem.frame), 32'h0000_0678);
    wr(AST_OFS_CTRL2, 32'h0000_0009);
    repeat (3) @(posedge clk);
    chk(32'(tx_irq), 32'h0000_0001);
    wr(AST_OFS_CTRL2, 32'h0000_0011);
    repeat (3) @(posedge clk);
    chk(32'(tx_irq), 32'h0000_0001);
    wr(AST_OFS_CTRL2, 32'h0000_0001);
    repeat (3) @(posedge clk);
    chk(32'(tx_irq), 32'h0000_0000);
    $display("t_tx done");
  endtask

  task automatic t_rx;
    wr(AST_OFS_CTRL2, 32'h0000_0023);
    rem.send({1'b1, 9'h0A5, 1'b0}, 11);
    chk(32'(rx_irq), 32'h0000_0001);
    rc(AST_OFS_STAT1, 32'h0000_0014, 32'h0000_0004);
    rc(AST_OFS_CTRL3, 32'h0000_0002, 32'h0000_0000);
    rc(AST_OFS_DATA, 32'h0000_00FF, 32'h0000_00A5);
    wr(AST_OFS_CTRL1, 32'h0000_0001);
    rem.send({2'b01, 8'hA5, 1'b0}, 10);
    rc(AST_OFS_STAT1, 32'h0000_0014, 32'h0000_0004);
    rc(AST_OFS_CTRL3, 32'h0000_0002, 32'h0000_0002);
    rc(AST_OFS_DATA, 32'h0000_00FF, 32'h0000_00A5);
    rem.send({2'b00, 8'h33, 1'b0}, 10);
    rc(AST_OFS_STAT1, 32'h0000_001C, 32'h0000_0014);
    rc(AST_OFS_DATA, 32'h0000_00FF, 32'h0000_0033);
    rem.send(11'h000, 10);
    rc(AST_OFS_STAT2, 32'h0000_0001, 32'h0000_0001);
    rc(AST_OFS_STAT1, 32'h0000_0014, 32'h0000_0014);
    rc(AST_OFS_CTRL3, 32'h0000_0002, 32'h0000_0000);
    rc(AST_OFS_DATA, 32'h0000_00FF, 32'h0000_0000);
    $display("t_rx done");
  endtask

  // Toggling transmit enable mid-frame must put one idle character before the next frame
  task automatic t_idle;
    rc(AST_OFS_STAT1, 32'h0000_0001, 32'h0000_0001);
    wr(AST_OFS_DATA, 32'h0000_0055);
    wait_out(1'b0);
    wr(AST_OFS_CTRL2, 32'h0000_0000);
    wr(AST_OFS_CTRL2, 32'h0000_0001);
    rc(AST_OFS_STAT1, 32'h0000_0001, 32'h0000_0001);
    wr(AST_OFS_DATA, 32'h0000_00C3);
    wait_frame();
    chk(32'(rem.frame[9:0]), 32'h0000_02AA);
    wait_out(1'b0);
    chk(32'(c >= 120 && c <= 150), 32'h0000_0001);
    wait_frame();
    chk(32'(rem.frame[9:0]), 32'h0000_0386);
    wr(AST_OFS_BAUD, 32'h0000_0001);
    rc(AST_OFS_BAUD, 32'h0000_00FF, 32'h0000_0001);
    rc(AST_OFS_STAT1, 32'h0000_0001, 32'h0000_0001);
    wr(AST_OFS_DATA, 32'h0000_00FE);
    wait_out(1'b0);
    wait_out(1'b1);
    chk(32'(c >= 60 && c <= 68), 32'h0000_0001);
    repeat (270) @(posedge clk);
    wr(AST_OFS_BAUD, 32'h0000_0000);
    $display("t_idle done");
  endtask

  task automatic t_break;
    wr(AST_OFS_CTRL2, 32'h0000_0005);
    wait_out(1'b0);
    repeat (480) @(posedge clk);
    chk(32'(sout), 32'h0000_0000);
    wr(AST_OFS_CTRL2, 32'h0000_0001);
    wait_out(1'b1);
    chk(32'(c <= 176), 32'h0000_0001);
    repeat (14) @(posedge clk);
    chk(32'(sout), 32'h0000_0001);
    repeat (40) @(posedge clk);
    wr(AST_OFS_CTRL1, 32'h0000_0005);
    repeat (3) @(posedge clk);
    chk(32'(sout), 32'h0000_0000);
    repeat (20) @(posedge clk);
    wr(AST_OFS_CTRL1, 32'h0000_0000);
    repeat (3) @(posedge clk);
    chk(32'(soe), 32'h0000_0000);
    $display("t_break done");
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_tx();
    t_rx();
    t_idle();
    t_break();
    finish_test();
  end

  // Whole run needs a few thousand clocks
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    finish_test();
  end
endmodule // test_async_serial_transceiver
